// >>> src/obd_pkg.sv
package obd_pkg;

	// ------------------------------------------------------------
	// Element decode and sizes
	// ------------------------------------------------------------
	localparam logic [4:0] OBD_DEC_DIP_RST = 5'h10;
	localparam logic [4:0] OBD_DEC_CROM_RST = 5'h11;
	localparam logic [4:0] OBD_DEC_RXBUF_RST = 5'h12;
	localparam logic [4:0] OBD_DEC_STORE_RST = 5'h13;
	localparam int OBD_RX_DEPTH = 2048;
	localparam int OBD_RX_AW = 11;
	localparam int OBD_STORE_WORDS = 100;
	localparam int OBD_STORE_WIDTH = 14;
	localparam int OBD_SER_BIT = 7;
	localparam logic [7:0] OBD_BYTE_RST = 8'h00;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		OBD_EL_NONE = 4'h0,
		OBD_EL_DIP = 4'h1,
		OBD_EL_CROM = 4'h2,
		OBD_EL_RXBUF = 4'h4,
		OBD_EL_STORE = 4'h8
	} obd_elem_t;

	typedef enum logic [3:0] {
		OBD_ST_IDLE = 4'h1,
		OBD_ST_ADDR = 4'h2,
		OBD_ST_RD = 4'h4,
		OBD_ST_WR = 4'h8
	} obd_state_t;

	typedef struct packed {
		logic [7:0] upper;
		logic [7:0] low;
	} obd_addr_t;

endpackage : obd_pkg

// >>> src/obd_rx_ram.sv
module obd_rx_ram #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2048,
	parameter int AW = 11
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [WIDTH-1:0] wdata,
	output logic [WIDTH-1:0] rdata
);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] rdata_d;
	logic [WIDTH-1:0] rdata_q;

	always_comb begin
		rdata_d = mem[addr];
	end

	// Array has no reset, so contents after power-up are undefined
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign rdata = rdata_q;

endmodule : obd_rx_ram

// >>> src/obd_bus_decode.sv
module obd_bus_decode
	import obd_pkg::*;
#(
	parameter bit HAS_RX_BUFFER = 1'b1,
	parameter logic [4:0] DEC_DIP = OBD_DEC_DIP_RST,
	parameter logic [4:0] DEC_CROM = OBD_DEC_CROM_RST,
	parameter logic [4:0] DEC_RXBUF = OBD_DEC_RXBUF_RST,
	parameter logic [4:0] DEC_STORE = OBD_DEC_STORE_RST
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ale,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [7:0] host_upper_address_lines,
	input wire logic [7:0] host_muxed_addr_data_lines_i,
	output logic [7:0] host_muxed_addr_data_lines_o,
	output logic host_muxed_addr_data_lines_oe,
	output logic [7:0] buffered_upper_address,
	output logic [7:0] latched_low_address,
	output obd_elem_t element_select,
	input wire logic [7:0] option_switch,
	input wire logic [7:0] char_rom_data,
	input wire logic serial_memory_data_line_i,
	output logic serial_memory_data_line_o,
	output logic serial_memory_data_line_oe,
	output logic serial_memory_shift_clock,
	output logic [2:0] serial_memory_opcode_lines
);

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	// Bits 2:0 stay free so they can carry the store opcode and the
	// top of the receive buffer address.
	function automatic obd_elem_t obd_decode(input logic [7:0] up);
		obd_elem_t el;
		el = OBD_EL_NONE;
		if (up[7:3] == DEC_DIP) begin
			el = OBD_EL_DIP;
		end else if (up[7:3] == DEC_CROM) begin
			el = OBD_EL_CROM;
		end else if (up[7:3] == DEC_RXBUF && HAS_RX_BUFFER) begin
			el = OBD_EL_RXBUF;
		end else if (up[7:3] == DEC_STORE) begin
			el = OBD_EL_STORE;
		end
		return el;
	endfunction : obd_decode

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	obd_state_t st_q, st_d;
	obd_addr_t addr_q, addr_d;
	obd_elem_t sel_q, sel_d;
	logic [7:0] rdat_q, rdat_d;
	logic oe_q, oe_d;
	logic ser_drv_q, ser_drv_d;
	logic ser_bit_q, ser_bit_d;
	logic wr_pulse;
	logic ram_we;
	logic [7:0] ram_rdata;

	always_comb begin
		st_d = st_q;
		addr_d = addr_q;
		sel_d = sel_q;
		wr_pulse = 1'b0;
		if (ale) begin
			st_d = OBD_ST_ADDR;
			addr_d = '{upper: host_upper_address_lines,
				low: host_muxed_addr_data_lines_i};
			sel_d = obd_decode(host_upper_address_lines);
		end else begin
			case (st_q)
				OBD_ST_ADDR: begin
					if (!rd_n) begin
						st_d = OBD_ST_RD;
					end else if (!wr_n) begin
						st_d = OBD_ST_WR;
						wr_pulse = 1'b1;
					end
				end
				OBD_ST_RD: begin
					if (rd_n) begin
						st_d = OBD_ST_IDLE;
					end
				end
				OBD_ST_WR: begin
					if (wr_n) begin
						st_d = OBD_ST_IDLE;
					end
				end
				OBD_ST_IDLE: begin
					st_d = OBD_ST_IDLE;
				end
				default: begin
					st_d = OBD_ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Data phase
	// ------------------------------------------------------------
	// Only buffer and store accept writes; others ignore them
	assign ram_we = wr_pulse && sel_q == OBD_EL_RXBUF;

	always_comb begin
		rdat_d = rdat_q;
		if (st_q == OBD_ST_RD) begin
			case (sel_q)
				OBD_EL_DIP: rdat_d = option_switch;
				OBD_EL_CROM: rdat_d = char_rom_data;
				OBD_EL_RXBUF: rdat_d = ram_rdata;
				OBD_EL_STORE: begin
					rdat_d = OBD_BYTE_RST;
					rdat_d[OBD_SER_BIT] = serial_memory_data_line_i;
				end
				default: rdat_d = OBD_BYTE_RST;
			endcase
		end
		oe_d = st_q == OBD_ST_RD && sel_q != OBD_EL_NONE;
	end

	// Store bit is held on the line across shift clock toggles and is
	// dropped as soon as a read starts or another element is addressed.
	always_comb begin
		ser_bit_d = ser_bit_q;
		ser_drv_d = ser_drv_q;
		if (sel_d != OBD_EL_STORE || st_d == OBD_ST_RD) begin
			ser_drv_d = 1'b0;
		end else if (wr_pulse) begin
			ser_drv_d = 1'b1;
			ser_bit_d = host_muxed_addr_data_lines_i[OBD_SER_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= OBD_ST_IDLE;
			addr_q <= '0;
			sel_q <= OBD_EL_NONE;
			rdat_q <= OBD_BYTE_RST;
			oe_q <= 1'b0;
			ser_drv_q <= 1'b0;
			ser_bit_q <= 1'b0;
		end else begin
			st_q <= st_d;
			addr_q <= addr_d;
			sel_q <= sel_d;
			rdat_q <= rdat_d;
			oe_q <= oe_d;
			ser_drv_q <= ser_drv_d;
			ser_bit_q <= ser_bit_d;
		end
	end

	obd_rx_ram #(
		.WIDTH(8),
		.DEPTH(OBD_RX_DEPTH),
		.AW(OBD_RX_AW)
	) u_rx_ram (
		.clk(clk),
		.rst_n(rst_n),
		.we(ram_we),
		.addr({addr_q.upper[2:0], addr_q.low}),
		.wdata(host_muxed_addr_data_lines_i),
		.rdata(ram_rdata)
	);

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign buffered_upper_address = addr_q.upper;
	assign latched_low_address = addr_q.low;
	assign element_select = sel_q;
	assign host_muxed_addr_data_lines_o = rdat_q;
	assign host_muxed_addr_data_lines_oe = oe_q;
	assign serial_memory_data_line_o = ser_bit_q;
	assign serial_memory_data_line_oe = ser_drv_q;
	// The external word store is clocked and steered straight from the
	// latched address, so the host alone sets its pace.
	assign serial_memory_shift_clock = addr_q.low[0];
	assign serial_memory_opcode_lines = addr_q.upper[2:0];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_store_write;
		wr_pulse && sel_q == OBD_EL_STORE;
	endsequence

	sequence s_read_start(obd_elem_t el);
		st_q == OBD_ST_RD && sel_q == el && !ale;
	endsequence

	property p_latch;
		@(posedge clk) disable iff (!rst_n)
		ale |=> buffered_upper_address == $past(host_upper_address_lines)
			&& latched_low_address == $past(host_muxed_addr_data_lines_i);
	endproperty
	a_latch: assert property (p_latch)
		else $error("address not latched on strobe");

	property p_hold;
		@(posedge clk) disable iff (!rst_n)
		!ale |=> $stable(buffered_upper_address) && $stable(latched_low_address);
	endproperty
	a_hold: assert property (p_hold)
		else $error("latched address moved without strobe");

	property p_onehot;
		@(posedge clk) disable iff (!rst_n)
		$onehot0(element_select);
	endproperty
	a_onehot: assert property (p_onehot)
		else $error("more than one element selected");

	property p_one_write;
		@(posedge clk) disable iff (!rst_n)
		wr_pulse ##1 !ale |-> !wr_pulse [*2];
	endproperty
	a_one_write: assert property (p_one_write)
		else $error("second byte written in one host cycle");

	property p_write_target;
		@(posedge clk) disable iff (!rst_n)
		ram_we |-> st_q == OBD_ST_ADDR && !wr_n && rd_n && !ale
			&& element_select == OBD_EL_RXBUF && HAS_RX_BUFFER;
	endproperty
	a_write_target: assert property (p_write_target)
		else $error("buffer written while not selected");

	property p_buf_read;
		@(posedge clk) disable iff (!rst_n)
		s_read_start(OBD_EL_RXBUF) |=>
			host_muxed_addr_data_lines_o == $past(ram_rdata)
			&& host_muxed_addr_data_lines_oe;
	endproperty
	a_buf_read: assert property (p_buf_read)
		else $error("buffer read data wrong");

	property p_store_write;
		@(posedge clk) disable iff (!rst_n)
		s_store_write |=> serial_memory_data_line_oe
			&& serial_memory_data_line_o
			== $past(host_muxed_addr_data_lines_i[OBD_SER_BIT]);
	endproperty
	a_store_write: assert property (p_store_write)
		else $error("store bit not driven after write");

	property p_store_read;
		@(posedge clk) disable iff (!rst_n)
		s_read_start(OBD_EL_STORE) |=>
			host_muxed_addr_data_lines_o[OBD_SER_BIT]
			== $past(serial_memory_data_line_i)
			&& !serial_memory_data_line_oe;
	endproperty
	a_store_read: assert property (p_store_read)
		else $error("store bit not returned on read");

	property p_undriven;
		@(posedge clk) disable iff (!rst_n)
		(st_q != OBD_ST_RD || sel_q == OBD_EL_NONE)
			|=> !host_muxed_addr_data_lines_oe;
	endproperty
	a_undriven: assert property (p_undriven)
		else $error("shared lines driven without selection");

	property p_ser_undriven;
		@(posedge clk) disable iff (!rst_n)
		serial_memory_data_line_oe |-> element_select == OBD_EL_STORE;
	endproperty
	a_ser_undriven: assert property (p_ser_undriven)
		else $error("store line driven while store not selected");

endmodule : obd_bus_decode

// >>> verif/obd_store_model.sv
module obd_store_model
	import obd_pkg::*;
(
	input wire logic rst_n,
	input wire logic shift_clk,
	input wire logic line,
	output logic drive_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Serial word, loops the last bit back
	// ------------------------------------------------------------
	logic [OBD_STORE_WIDTH-1:0] word_q;
	// Takes the line level on every rising shift clock
	always_ff @(posedge shift_clk or negedge rst_n) begin
		if (!rst_n) begin
			word_q <= '0;
		end else begin
			word_q <= {word_q[OBD_STORE_WIDTH-2:0], line};
		end
	end
	assign drive_o = word_q[0];
endmodule : obd_store_model

// >>> verif/option_board_bus_decode_tb.sv
module option_board_bus_decode_tb
	import obd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, ale, rd_n, wr_n, sl_o, sl_oe, sclk, sl_i, m_o, moe;
	logic [7:0] up, mi, mo, bua, lla, sw, crom;
	logic [2:0] opc;
	obd_elem_t el;
	obd_elem_t el_nb;
	int fail_count = 0;
	int checked = 0;
	// ------------------------------------------------------------
	// Far side: glyph ROM and serial store
	// ------------------------------------------------------------
	assign crom = lla ^ 8'hA5;
	assign sl_i = sl_oe ? sl_o : m_o;
	obd_store_model store (.rst_n(rst_n), .shift_clk(sclk), .line(sl_i),
		.drive_o(m_o));
	obd_bus_decode dut (.clk(clk), .rst_n(rst_n), .ale(ale), .rd_n(rd_n),
		.wr_n(wr_n), .host_upper_address_lines(up),
		.host_muxed_addr_data_lines_i(mi),
		.host_muxed_addr_data_lines_o(mo),
		.host_muxed_addr_data_lines_oe(moe), .buffered_upper_address(bua),
		.latched_low_address(lla), .element_select(el), .option_switch(sw),
		.char_rom_data(crom), .serial_memory_data_line_i(sl_i),
		.serial_memory_data_line_o(sl_o), .serial_memory_data_line_oe(sl_oe),
		.serial_memory_shift_clock(sclk), .serial_memory_opcode_lines(opc));
	// Variant without the receive buffer, so its decode is exercised too
	obd_bus_decode #(.HAS_RX_BUFFER(1'b0)) dut_nobuf (.clk(clk),
		.rst_n(rst_n), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
		.host_upper_address_lines(up), .host_muxed_addr_data_lines_i(mi),
		.host_muxed_addr_data_lines_o(), .host_muxed_addr_data_lines_oe(),
		.buffered_upper_address(), .latched_low_address(),
		.element_select(el_nb), .option_switch(sw), .char_rom_data(crom),
		.serial_memory_data_line_i(sl_i), .serial_memory_data_line_o(),
		.serial_memory_data_line_oe(), .serial_memory_shift_clock(),
		.serial_memory_opcode_lines());
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic end_sim();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim
	task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask : cmp_byte
	task automatic cmp_el(input obd_elem_t g, input obd_elem_t e);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask : cmp_el
	// ------------------------------------------------------------
	// Host cycles
	// ------------------------------------------------------------
	task automatic addr_ph(input logic [7:0] u, l, input obd_elem_t e);
		@(posedge clk);
		ale <= 1'b1;
		up <= u;
		mi <= l;
		@(posedge clk);
		ale <= 1'b0;
		mi <= ~l;
		#1;
		cmp_byte(bua, u);
		cmp_byte(lla, l);
		cmp_el(el, e);
		cmp_byte({7'h00, sclk}, {7'h00, l[0]});
		cmp_byte({5'h00, opc}, {5'h00, u[2:0]});
	endtask : addr_ph
	task automatic rd_ph(input logic oe_e, input logic [7:0] d);
		@(posedge clk);
		rd_n <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		cmp_byte({7'h00, moe}, {7'h00, oe_e});
		if (oe_e) cmp_byte(mo, d);
		@(posedge clk);
		rd_n <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		cmp_byte({7'h00, moe}, 8'h00);
	endtask : rd_ph
	task automatic wr_ph(input logic [7:0] d);
		@(posedge clk);
		wr_n <= 1'b0;
		mi <= d;
		@(posedge clk);
		wr_n <= 1'b1;
		@(posedge clk);
		#1;
	endtask : wr_ph
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_switch_glyph();
		addr_ph(8'h80, 8'h01, OBD_EL_DIP);
		wr_ph(8'h80);
		cmp_byte({7'h00, sl_oe}, 8'h00);
		// A read needs an address phase of its own
		addr_ph(8'h80, 8'h01, OBD_EL_DIP);
		cmp_el(el_nb, OBD_EL_DIP);
		rd_ph(1'b1, 8'h96);
		addr_ph(8'h8F, 8'h3C, OBD_EL_CROM);
		rd_ph(1'b1, 8'h99);
	endtask : t_switch_glyph
	task automatic t_rxbuf();
		addr_ph(8'h97, 8'hFF, OBD_EL_RXBUF);
		cmp_el(el_nb, OBD_EL_NONE);
		wr_ph(8'h5A);
		addr_ph(8'h90, 8'h00, OBD_EL_RXBUF);
		wr_ph(8'hC3);
		addr_ph(8'h97, 8'hFF, OBD_EL_RXBUF);
		rd_ph(1'b1, 8'h5A);
		addr_ph(8'h90, 8'h00, OBD_EL_RXBUF);
		rd_ph(1'b1, 8'hC3);
	endtask : t_rxbuf
	task automatic t_store();
		logic v;
		for (int b = 0; b < 2; b++) begin
			v = (b == 0);
			// Opcode lines stay at 5 over the whole operation
			addr_ph(8'h9D, 8'h00, OBD_EL_STORE);
			wr_ph({v, 7'h00});
			cmp_byte({6'h00, sl_oe, sl_o}, {6'h00, 1'b1, v});
			addr_ph(8'h9D, 8'h01, OBD_EL_STORE);
			addr_ph(8'h9D, 8'h00, OBD_EL_STORE);
			rd_ph(1'b1, {v, 7'h00});
		end
		addr_ph(8'h9D, 8'h00, OBD_EL_STORE);
		wr_ph(8'h80);
		addr_ph(8'hA0, 8'h00, OBD_EL_NONE);
		cmp_byte({7'h00, sl_oe}, 8'h00);
		rd_ph(1'b0, 8'h00);
	endtask : t_store
	initial begin
		#4000;
		fail_count++;
		end_sim();
	end
	initial begin
		rst_n = 1'b0;
		ale = 1'b0;
		rd_n = 1'b1;
		wr_n = 1'b1;
		up = 8'h00;
		mi = 8'h00;
		sw = 8'h96;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		cmp_el(el, OBD_EL_NONE);
		cmp_byte({6'h00, moe, sl_oe}, 8'h00);
		t_switch_glyph();
		t_rxbuf();
		t_store();
		end_sim();
	end
endmodule : option_board_bus_decode_tb
